// ---- hdl/vpi_forward.sv ----
/*
 * Per-frame forwarding mask and egress tag decision with VLAN and
 * private VLAN tables behind a classic Wishbone slave.
 * Assumes frame headers are presented by same-clock parsing logic and
 * that ingress port numbers are below NUM_PORTS.
 */
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module vpi_forward
#(
	parameter int NUM_PORTS = 10,
	parameter int VLAN_CNT  = 16
)
(
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          cyc_i,
	input  wire logic                          stb_i,
	input  wire logic                          we_i,
	input  wire logic [vpi_pkg::VPI_AW-1:0]    adr_i,
	input  wire logic [3:0]                    sel_i,
	input  wire logic [31:0]                   dat_i,
	output logic      [31:0]                   dat_o,
	output logic                               ack_o,
	input  wire logic                          req_valid_i,
	input  wire logic [$clog2(NUM_PORTS)-1:0]  req_port_i,
	input  wire logic                          req_tagged_i,
	input  wire logic [vpi_pkg::VPI_VID_W-1:0] req_vid_i,
	output logic                               fwd_valid_o,
	output logic      [$clog2(NUM_PORTS)-1:0]  fwd_src_o,
	output logic      [vpi_pkg::VPI_VID_W-1:0] fwd_vid_o,
	output logic      [NUM_PORTS-1:0]          fwd_mask_o,
	output logic      [NUM_PORTS-1:0]          fwd_tag_o,
	output logic                               fwd_drop_o
);
	import vpi_pkg::*;

	localparam int PW = $clog2(NUM_PORTS);
	localparam int VW = $clog2(VLAN_CNT);
	typedef logic [NUM_PORTS-1:0] vpi_pmask_t;

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[8*b +: 8] = wr[8*b +: 8];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Configuration state
	vpi_pmask_t          iso_q, iso_d, filt_q, filt_d, egr_q, egr_d, trunk_q, trunk_d;
	logic [11:0]         port_default_vlan_id_q  [NUM_PORTS];
	logic [11:0]         port_default_vlan_id_d  [NUM_PORTS];
	vpi_pmask_t          vlan_q  [VLAN_CNT];
	vpi_pmask_t          vlan_d  [VLAN_CNT];
	vpi_pmask_t          pvlan_q [VLAN_CNT];
	vpi_pmask_t          pvlan_d [VLAN_CNT];
	logic [VLAN_CNT-1:0] allow_q [NUM_PORTS];
	logic [VLAN_CNT-1:0] allow_d [NUM_PORTS];
	logic [15:0]         nfwd_q, nfwd_d, ndrop_q, ndrop_d;
	logic                ack_q, ack_d;
	logic [31:0]         rd_q, rd_d;
	logic [31:0]         cur, wv;
	logic [3:0]          tab, ix;
	logic                wr;

	// Read decode, then byte-merge the addressed word for writes
	always_comb
	begin
		tab = adr_i[9:6];
		ix  = adr_i[5:2];
		cur = 32'h0000_0000;
		if (tab == TAB_CTRL && ix == OFS_ISO)
			cur = 32'(iso_q);
		else if (tab == TAB_CTRL && ix == OFS_FILT)
			cur = 32'(filt_q);
		else if (tab == TAB_CTRL && ix == OFS_EGR_TAG)
			cur = 32'(egr_q);
		else if (tab == TAB_CTRL && ix == OFS_TRUNK)
			cur = 32'(trunk_q);
		else if (tab == TAB_CTRL && ix == OFS_STATUS)
			cur = {ndrop_q, nfwd_q};
		else if (tab == TAB_PORT_DEFAULT_VLAN_ID && 32'(ix) < NUM_PORTS)
			cur = 32'(port_default_vlan_id_q[ix]);
		else if (tab == TAB_VLAN && 32'(ix) < VLAN_CNT)
			cur = 32'(vlan_q[ix]);
		else if (tab == TAB_PVLAN && 32'(ix) < VLAN_CNT)
			cur = 32'(pvlan_q[ix]);
		else if (tab == TAB_ALLOW && 32'(ix) < NUM_PORTS)
			cur = 32'(allow_q[ix]);
		wv = merge(cur, dat_i, sel_i);
		wr = cyc_i && stb_i && we_i && !ack_q;
	end

	// Register writes; unmapped words and status ignore writes
	always_comb
	begin
		iso_d   = iso_q;
		filt_d  = filt_q;
		egr_d   = egr_q;
		trunk_d = trunk_q;
		port_default_vlan_id_d  = port_default_vlan_id_q;
		vlan_d  = vlan_q;
		pvlan_d = pvlan_q;
		allow_d = allow_q;
		ack_d   = cyc_i && stb_i && !ack_q;
		rd_d    = (cyc_i && stb_i && !ack_q) ? cur : 32'h0000_0000;
		if (wr)
		begin
			// [RULE4] one role per port
			if (tab == TAB_CTRL && ix == OFS_ISO)
				iso_d = wv[NUM_PORTS-1:0];
			else if (tab == TAB_CTRL && ix == OFS_FILT)
				filt_d = wv[NUM_PORTS-1:0];
			else if (tab == TAB_CTRL && ix == OFS_EGR_TAG)
				egr_d = wv[NUM_PORTS-1:0];
			else if (tab == TAB_CTRL && ix == OFS_TRUNK)
				trunk_d = wv[NUM_PORTS-1:0];
			else if (tab == TAB_PORT_DEFAULT_VLAN_ID && 32'(ix) < NUM_PORTS)
				port_default_vlan_id_d[ix] = wv[11:0];
			else if (tab == TAB_VLAN && 32'(ix) < VLAN_CNT)
				vlan_d[ix] = wv[NUM_PORTS-1:0];
			else if (tab == TAB_PVLAN && 32'(ix) < VLAN_CNT)
				pvlan_d[ix] = wv[NUM_PORTS-1:0];
			else if (tab == TAB_ALLOW && 32'(ix) < NUM_PORTS)
				allow_d[ix] = wv[VLAN_CNT-1:0];
		end
	end

	// Configuration registers and bus answer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// [RULE5] isolation clear at reset
			iso_q   <= '0;
			filt_q  <= NUM_PORTS'(RST_FILT);
			egr_q   <= '0;
			trunk_q <= '0;
			ack_q   <= 1'b0;
			rd_q    <= 32'h0000_0000;
			// [RULE14] all ports in VLAN 1 and private VLAN 1
			for (int p = 0; p < NUM_PORTS; p++)
			begin
				port_default_vlan_id_q[p]  <= RST_PORT_DEFAULT_VLAN_ID;
				allow_q[p] <= VLAN_CNT'(RST_ALLOW);
			end
			for (int v = 0; v < VLAN_CNT; v++)
			begin
				vlan_q[v]  <= (v == RST_VLAN_IX) ? '1 : '0;
				pvlan_q[v] <= (v == RST_PVLAN_IX) ? '1 : '0;
			end
		end
		else
		begin
			iso_q   <= iso_d;
			filt_q  <= filt_d;
			egr_q   <= egr_d;
			trunk_q <= trunk_d;
			port_default_vlan_id_q  <= port_default_vlan_id_d;
			vlan_q  <= vlan_d;
			pvlan_q <= pvlan_d;
			allow_q <= allow_d;
			ack_q   <= ack_d;
			rd_q    <= rd_d;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = rd_q;

	////////////////////////////////////////////////////////////////////////////
	// Frame lookup, one cycle from request to decision
	logic [11:0]    vid_c, port_default_vlan_id_sel;
	logic           in_tab, drop_c;
	logic [VW-1:0]  vix;
	vpi_pmask_t     vmask, pvm, ok, src, dest;
	logic           fv_q, fv_d, fdrop_q, fdrop_d;
	logic [PW-1:0]  fsrc_q, fsrc_d;
	logic [11:0]    fvid_q, fvid_d;
	vpi_pmask_t     fmask_q, fmask_d, ftag_q, ftag_d;

	always_comb
	begin
		port_default_vlan_id_sel = port_default_vlan_id_q[req_port_i];
		// [RULE8] [RULE9] classification
		vid_c  = req_tagged_i ? req_vid_i : port_default_vlan_id_sel;
		in_tab = 32'(vid_c) < VLAN_CNT;
		vix    = vid_c[VW-1:0];
		src    = vpi_pmask_t'(1) << req_port_i;
		// [RULE7] VLAN membership, unknown VLAN has none
		vmask  = in_tab ? vlan_q[vix] : '0;
		// [RULE6] private VLAN source-port mask on top
		pvm    = '0;
		for (int j = 0; j < VLAN_CNT; j++)
			if (pvlan_q[j][req_port_i])
				pvm = pvm | pvlan_q[j];
		// [RULE12] trunks carry allowed VLANs only
		for (int p = 0; p < NUM_PORTS; p++)
			ok[p] = !trunk_q[p] || (in_tab && allow_q[p][vix]);
		// [RULE1] [RULE15] member mask without ingress port
		dest = vmask & pvm & ok & ~src;
		// [RULE2] [RULE3] isolated ingress reaches promiscuous only
		if (iso_q[req_port_i])
			dest = dest & ~iso_q;
		// [RULE13] [RULE14] ingress filter and membership
		drop_c  = (filt_q[req_port_i] && !vmask[req_port_i]) || !pvm[req_port_i];
		fv_d    = req_valid_i;
		fsrc_d  = req_valid_i ? req_port_i : fsrc_q;
		fvid_d  = req_valid_i ? vid_c : fvid_q;
		fdrop_d = req_valid_i && drop_c;
		fmask_d = (req_valid_i && !drop_c) ? dest : '0;
		// [RULE10] [RULE11] tag kept on tagged or trunk egress
		ftag_d  = (req_valid_i && !drop_c) ? (dest & (egr_q | trunk_q)) : '0;
		nfwd_d  = nfwd_q + 16'(req_valid_i && !drop_c);
		ndrop_d = ndrop_q + 16'(req_valid_i && drop_c);
	end

	// Decision registers and frame counters
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fv_q    <= 1'b0;
			fsrc_q  <= '0;
			fvid_q  <= '0;
			fdrop_q <= 1'b0;
			fmask_q <= '0;
			ftag_q  <= '0;
			nfwd_q  <= 16'h0000;
			ndrop_q <= 16'h0000;
		end
		else
		begin
			fv_q    <= fv_d;
			fsrc_q  <= fsrc_d;
			fvid_q  <= fvid_d;
			fdrop_q <= fdrop_d;
			fmask_q <= fmask_d;
			ftag_q  <= ftag_d;
			nfwd_q  <= nfwd_d;
			ndrop_q <= ndrop_d;
		end
	end

	assign fwd_valid_o = fv_q;
	assign fwd_src_o   = fsrc_q;
	assign fwd_vid_o   = fvid_q;
	assign fwd_drop_o  = fdrop_q;
	assign fwd_mask_o  = fmask_q;
	assign fwd_tag_o   = ftag_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_wb_req;
		cyc_i && stb_i && !ack_q;
	endsequence
	sequence s_ack_pulse;
		ack_o ##1 !ack_o;
	endsequence

	chk_wb_ack_pulse: assert property (s_wb_req |=> s_ack_pulse)
		else $error("wishbone ack not a single pulse");
	// Own disable: the default one would hide every reset cycle
	chk_iso_reset: assert property (disable iff (1'b0) rst_i |=> iso_q == '0) // [RULE5]
		else $error("isolation not clear after reset");
	chk_no_echo: assert property (fwd_valid_o |-> fwd_mask_o[fwd_src_o] == 1'b0) // [RULE15]
		else $error("frame sent back to ingress");
	chk_iso_promisc: assert property (fwd_valid_o && $past(iso_q[req_port_i])
		|-> (fwd_mask_o & $past(iso_q)) == '0) // [RULE3]
		else $error("isolated frame reached isolated port");
	chk_untag_port_default_vlan_id: assert property (req_valid_i && !req_tagged_i
		|=> fwd_vid_o == $past(port_default_vlan_id_sel)) // [RULE8]
		else $error("untagged frame not on default VLAN");
	chk_tag_vid: assert property (req_valid_i && req_tagged_i
		|=> fwd_vid_o == $past(req_vid_i)) // [RULE9]
		else $error("tagged frame VLAN mismatch");
	chk_vlan_member: assert property (req_valid_i |=> (fwd_mask_o & ~$past(vmask)) == '0) // [RULE7]
		else $error("frame forwarded outside its VLAN");
	chk_filter_drop: assert property (req_valid_i && filt_q[req_port_i] && !vmask[req_port_i]
		|=> fwd_drop_o && fwd_mask_o == '0) // [RULE13]
		else $error("filtered frame not dropped");
	chk_trunk_tag: assert property (fwd_valid_o |-> (fwd_mask_o & $past(trunk_q) & ~fwd_tag_o) == '0) // [RULE12]
		else $error("trunk egress left untagged");
	chk_promisc_mask: assert property (req_valid_i && !iso_q[req_port_i] && !drop_c
		|=> fwd_mask_o == $past(vmask & pvm & ok & ~src)) // [RULE1]
		else $error("promiscuous mask wrong");
	// [RULE10] [RULE11] tag follows egress setting
	chk_untag_strip: assert property (fwd_valid_o // [RULE10]
		|-> (fwd_tag_o & ~$past(egr_q | trunk_q)) == '0)
		else $error("untagged egress port left tagged");
	chk_tag_keep: assert property (fwd_valid_o // [RULE11]
		|-> (fwd_mask_o & $past(egr_q) & ~fwd_tag_o) == '0)
		else $error("tagged egress port lost its tag");
	// [RULE14] ingress outside every private VLAN
	chk_pvlan_drop: assert property (req_valid_i && !pvm[req_port_i] // [RULE14]
		|=> fwd_drop_o && fwd_mask_o == '0)
		else $error("frame outside private VLANs not dropped");
endmodule // vpi_forward

// ---- hdl/vpi_pkg.sv ----
/*
 * Constants for the VLAN and private VLAN forwarding block: register
 * offsets, table layout and reset values.
 * Assumes a 32-bit classic Wishbone slave port and at most 16 ports.
 */
// Behaviour
// [RULE1] Promiscuous ingress uses plain VLAN member mask; here the private VLAN source-port mask is ANDed too
// [RULE2] Isolated ingress also ANDs private VLAN mask
// [RULE3] Isolated ports receive only from promiscuous ports
// [RULE4] One isolation role per port, all private VLANs
// [RULE5] Isolation bit per port, clear after reset
// [RULE6] Private VLAN restriction applied after VLAN membership
// [RULE7] Forward only to members of classified VLAN
// [RULE8] Untagged frames take port default VLAN
// [RULE9] Tagged frames take VLAN from tag
// [RULE10] Untagged egress ports strip the tag
// [RULE11] Tagged egress ports keep classified tag
// [RULE12] Trunk tags all, carries allowed VLANs only
// [RULE13] Ingress filter drops frames from non-member port
// [RULE14] Forwarding needs VLAN and private VLAN membership; here ingress VLAN membership is checked only on ports whose filter bit is set
// [RULE15] Ingress port never in destination set
package vpi_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Bus geometry
	localparam int            VPI_AW       = 10;
	localparam int            VPI_VID_W    = 12;
	// Control word offsets (table select field zero)
	localparam logic [3:0]    OFS_ISO      = 4'h0;
	localparam logic [3:0]    OFS_FILT     = 4'h1;
	localparam logic [3:0]    OFS_EGR_TAG  = 4'h2;
	localparam logic [3:0]    OFS_TRUNK    = 4'h3;
	localparam logic [3:0]    OFS_STATUS   = 4'h4;
	// Table select field, byte offsets 0x040, 0x080, 0x0C0, 0x100
	localparam logic [3:0]    TAB_CTRL     = 4'h0;
	localparam logic [3:0]    TAB_PORT_DEFAULT_VLAN_ID     = 4'h1;
	localparam logic [3:0]    TAB_VLAN     = 4'h2;
	localparam logic [3:0]    TAB_PVLAN    = 4'h3;
	localparam logic [3:0]    TAB_ALLOW    = 4'h4;
	// Reset values
	localparam logic [11:0]   RST_PORT_DEFAULT_VLAN_ID     = 12'h001;
	localparam int            RST_VLAN_IX  = 1;
	localparam int            RST_PVLAN_IX = 1;
	localparam logic [31:0]   RST_FILT     = 32'h0000_0000;
	localparam logic [31:0]   RST_ALLOW    = 32'h0000_0002;
endpackage : vpi_pkg

// ---- test/vpi_link_partner.sv ----
/*
 * Stand-in for the link partners: offers one parsed frame header per call.
 * Assumes the block's clock; header lines are driven just after an edge.
 */
`timescale 1ns/100ps
module vpi_link_partner
#(
	parameter int PW = 4
)
(
	input  wire logic                          clk_i,
	output logic                               valid_o,
	output logic      [PW-1:0]                 port_o,
	output logic                               tagged_o,
	output logic      [vpi_pkg::VPI_VID_W-1:0] vid_o
);
	// Quiet lines at time zero
	initial
	begin
		valid_o = 1'b0;
		port_o = '0;
		tagged_o = 1'b0;
		vid_o = '0;
	end

	// One-cycle header, then inverted lines so a stale value is never trusted
	task automatic send(input logic [PW-1:0] p, input logic t,
		input logic [vpi_pkg::VPI_VID_W-1:0] v);
		@(posedge clk_i);
		valid_o <= 1'b1;
		port_o <= p;
		tagged_o <= t;
		vid_o <= v;
		@(posedge clk_i);
		valid_o <= 1'b0;
		port_o <= ~p;
		tagged_o <= ~t;
		vid_o <= ~v;
	endtask
endmodule // vpi_link_partner

// ---- test/vpi_forward_tb.sv ----
/*
 * Self-checking bench for the forwarding block: Wishbone set-up, headers
 * through the link partner stand-in. Assumes 10 ports, 16 VLAN entries.
 */
`timescale 1ns/100ps
module vpi_forward_tb;
	import vpi_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [9:0]  adr_i = '0;
	logic [3:0]  sel_i = 4'hf;
	logic [31:0] dat_i = '0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        rv, rt, fv, fd;
	logic [3:0]  rp, fs;
	logic [11:0] rvid, fvid;
	logic [9:0]  fm, ft;
	logic [31:0] rd;
	int          fail_count = 0;
	int          checks_done = 0;

	always #4 clk_i = ~clk_i;

	vpi_forward #(.NUM_PORTS(10), .VLAN_CNT(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .req_valid_i(rv), .req_port_i(rp),
		.req_tagged_i(rt), .req_vid_i(rvid), .fwd_valid_o(fv), .fwd_src_o(fs),
		.fwd_vid_o(fvid), .fwd_mask_o(fm), .fwd_tag_o(ft), .fwd_drop_o(fd));

	vpi_link_partner #(.PW(4)) lp (.clk_i(clk_i), .valid_o(rv), .port_o(rp),
		.tagged_o(rt), .vid_o(rvid));

	////////////////////////////////////////////////////////////////////////////
	// Shared compare, bus cycle and frame lookup
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Holds the request until ack is sampled high at an edge, releases there
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1);
		rd = dat_o;
		chk("ack_wait", 2, n);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic frm(input logic [3:0] p, input logic t, input logic [11:0] v,
		input logic [11:0] ev, input logic [9:0] em, input logic [9:0] et, input logic ed);
		lp.send(p, t, v);
		#1;
		chk("valid", 1, fv);
		chk("drop", ed, fd);
		chk("mask", em, fm);
		chk("tag", et, ft);
		chk("src", p, fs);
		if (!ed)
			chk("vid", ev, fvid);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_defaults();
		bus(0, 10'h000, 0);
		chk("iso", 0, rd);
		bus(0, 10'h040, 0);
		chk("pvid0", 1, rd);
		bus(0, 10'h3fc, 0);
		chk("unmapped", 0, rd);
		frm(2, 0, 12'h7aa, 1, 10'h3fb, 0, 0);
		$display("test defaults done");
	endtask

	task automatic t_vlan();
		bus(1, 10'h088, 32'h0000_0027);
		bus(1, 10'h040, 32'h0000_0002);
		bus(1, 10'h008, 32'h0000_0002);
		frm(0, 0, 12'h005, 2, 10'h026, 10'h002, 0);
		frm(5, 1, 12'h002, 2, 10'h007, 10'h002, 0);
		$display("test vlan done");
	endtask

	task automatic t_isolate();
		bus(1, 10'h000, 32'h0000_0003);
		bus(0, 10'h000, 0);
		chk("iso", 3, rd);
		frm(0, 0, 12'h009, 2, 10'h024, 0, 0);
		frm(1, 1, 12'h002, 2, 10'h024, 0, 0);
		frm(5, 1, 12'h002, 2, 10'h007, 10'h002, 0);
		$display("test isolate done");
	endtask

	task automatic t_drop();
		bus(1, 10'h004, 32'h0000_0008);
		frm(3, 1, 12'h002, 2, 0, 0, 1);
		bus(1, 10'h0c4, 32'h0000_03ef);
		frm(4, 0, 12'h002, 1, 0, 0, 1);
		$display("test drop done");
	endtask

	task automatic t_trunk();
		bus(1, 10'h00c, 32'h0000_0020);
		frm(2, 1, 12'h002, 2, 10'h003, 10'h002, 0);
		bus(1, 10'h114, 32'h0000_0006);
		frm(2, 1, 12'h002, 2, 10'h023, 10'h022, 0);
		$display("test trunk done");
	endtask

	// Counters, then a mid-run reset must restore the defaults
	task automatic t_reset();
		bus(0, 10'h010, 0);
		chk("status", 32'h0002_0008, rd);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, 10'h000, 0);
		chk("iso", 0, rd);
		bus(0, 10'h010, 0);
		chk("status", 0, rd);
		frm(2, 0, 12'h7aa, 1, 10'h3fb, 0, 0);
		$display("test reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Verdict, watchdog and main sequence
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Tests need well under a thousand cycles
	initial
	begin
		#100000;
		fail_count++;
		complete_run();
	end

	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_defaults();
		t_vlan();
		t_isolate();
		t_drop();
		t_trunk();
		t_reset();
		complete_run();
	end
endmodule // vpi_forward_tb
